// file: dv/flash_dev_model.sv
// Purpose: behavioural flash device on the pins
// Assumes: host strobes change off clock edges
// Notes: array word is a function of the address
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"
module flash_dev_model #(
  parameter logic [15:0] MAKER = 16'h0A5C, // Arbitrary value
  parameter logic [15:0] DEV1 = 16'h1B31, // Arbitrary value
  parameter logic [15:0] DEV2 = 16'h1B32, // Arbitrary value
  parameter logic [15:0] DEV3 = 16'h1B33 // Arbitrary value
) (
  input wire chipSel_n,
  input wire outEn_n,
  input wire writeEn_n,
  input wire hw_reset_n,
  input wire [22:0] addr_in,
  input wire hostOe,
  input wire [15:0] hostData,
  input wire busyReq,
  output wire [15:0] dataBus,
  output wire busy_out_n,
  output logic [22:0] wrAddr,
  output logic [15:0] wrData
);
  logic idMode = 1'b0; // Read mode at power-up
  logic [15:0] rdWord;
  logic [15:0] lastWord = 16'h0000;
  // Any bank answers a read, busy or not
  wire drive = !chipSel_n && !outEn_n && writeEn_n && hw_reset_n;
  // Earlier rise and later fall of the two write strobes
  wire wrAct_n = writeEn_n | chipSel_n | !outEn_n | !hw_reset_n;
  assign busy_out_n = !busyReq; // Busy ignores chip select
  // Released bus shows the inverse, never a stale word
  assign dataBus = drive ? rdWord : hostOe ? hostData : ~lastWord;
  always @(negedge drive)
    lastWord = rdWord;
  // Word select includes A0-A2 so page words differ
  always @*
    if (!idMode)
      rdWord = {addr_in[7:0] ^ 8'h5A, addr_in[7:0]};
    else
      case (addr_in[7:0])
        `ID_MAKER_ADDR: rdWord = MAKER;
        `ID_DEV1_ADDR: rdWord = DEV1;
        `ID_DEV2_ADDR: rdWord = DEV2;
        `ID_DEV3_ADDR: rdWord = DEV3;
        `ID_XBLK_ADDR: rdWord = 16'h0080;
        `ID_PROT_ADDR: rdWord = 16'h0001;
        default: rdWord = 16'h0000;
      endcase
  always @(negedge wrAct_n)
    wrAddr <= addr_in;
  // Command decode on low byte; busy refuses the mode
  always @(posedge wrAct_n or negedge hw_reset_n)
    if (!hw_reset_n)
      idMode <= 1'b0;
    else
    begin
      wrData <= dataBus;
      if (dataBus[7:0] == 8'h90 && busy_out_n)
        idMode <= 1'b1;
    end
endmodule
`default_nettype wire

// file: dv/flash_host_chk_sva.sv
// Purpose: pin checks on the flash host controller
// Assumes: one sys_clk domain
// Notes: bound onto the controller ports
`timescale 1ns/100ps
`default_nettype none
module flash_host_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire chipSel_n,
  input wire outEn_n,
  input wire writeEn_n,
  input wire hw_reset_n,
  input wire writeProt_n,
  input wire protOuter,
  input wire data_io_oe,
  input wire [22:0] addr_in,
  input wire [15:0] data_io_out,
  input wire busy_out_n,
  input wire flashBusy,
  input wire autoStandby
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Strobe combinations on the bus
  chk_read_strobes: assert property (!outEn_n |-> writeEn_n && !chipSel_n)
    else $error("read strobes wrong");
  chk_write_oe_high: assert property (!writeEn_n |-> outEn_n && !chipSel_n && data_io_oe)
    else $error("output strobe low in write");
  chk_no_fight: assert property (!outEn_n |-> !data_io_oe)
    else $error("host drives during read");
  // Address and data must not move while the device latches them
  chk_write_hold: assert property (!writeEn_n |-> $stable(addr_in) && $stable(data_io_out))
    else $error("write lines moved");
  chk_upper_zero: assert property (!writeEn_n |-> data_io_out[15:8] == 8'h00)
    else $error("upper byte not zero");
  chk_busy_flag: assert property (flashBusy == !busy_out_n)
    else $error("busy flag wrong");
  chk_prot_pin: assert property ($past(reset_n) |-> writeProt_n == !$past(protOuter))
    else $error("write protect pin wrong");
  chk_auto_idle: assert property ($rose(autoStandby) |-> $past(chipSel_n) && $past(chipSel_n, 2))
    else $error("standby flag too early");
  // Strobe pulses last whole cycles, far above the glitch filter
  chk_wr_pulse_wide: assert property ($fell(writeEn_n) |=> !writeEn_n)
    else $error("write strobe pulse too short");
  chk_cs_pulse_wide: assert property ($fell(chipSel_n) |=> !chipSel_n)
    else $error("chip select pulse too short");
  chk_reset_idle: assert property (!hw_reset_n |-> chipSel_n && outEn_n && writeEn_n)
    else $error("strobes active during reset");
  cover property ($fell(hw_reset_n));
  cover property ($fell(writeEn_n));
  cover property ($fell(outEn_n));
  cover property ($rose(autoStandby));
endmodule
bind flash_host_ctrl flash_host_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .chipSel_n(chipSel_n),
  .outEn_n(outEn_n), .writeEn_n(writeEn_n), .hw_reset_n(hw_reset_n), .writeProt_n(writeProt_n),
  .protOuter(protOuter),
  .data_io_oe(data_io_oe), .addr_in(addr_in), .data_io_out(data_io_out), .busy_out_n(busy_out_n),
  .flashBusy(flashBusy), .autoStandby(autoStandby));
`default_nettype wire

// file: dv/flash_host_ctrl_tb.sv
// Purpose: self-checking bench for the flash host
// Assumes: 20 MHz sys_clk, inputs at falling edge
// Notes: maker code below is arbitrary
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"
module flash_host_ctrl_tb;
  localparam logic [15:0] MAKER_ID = 16'h0A5C; // Arbitrary value
  localparam logic [15:0] DEV_ID1 = 16'h1B31; // Arbitrary value
  localparam logic [15:0] DEV_ID2 = 16'h1B32; // Arbitrary value
  localparam logic [15:0] DEV_ID3 = 16'h1B33; // Arbitrary value
  logic sys_clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, protOuter = 1'b0, busyReq = 1'b0;
  logic [1:0] opCode = 2'd0;
  logic [22:0] reqAddr = 23'h00_0000;
  logic [15:0] reqData = 16'h0000, got;
  wire reqReady, rspValid, flashBusy, chipSel_n, outEn_n, writeEn_n, hw_reset_n, writeProt_n;
  wire data_io_oe, busy_out_n, autoStandby;
  wire [15:0] rspData, data_io_out, dataBus, wrData;
  wire [7:0] rspStatus;
  wire [22:0] addr_in, wrAddr;
  int bad_count = 0, compares = 0;
  always #25 sys_clk = ~sys_clk;
  flash_host_ctrl dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady),
    .opCode(opCode), .reqAddr(reqAddr), .reqData(reqData), .protOuter(protOuter), .rspValid(rspValid),
    .rspData(rspData), .rspStatus(rspStatus), .flashBusy(flashBusy), .chipSel_n(chipSel_n),
    .outEn_n(outEn_n), .writeEn_n(writeEn_n), .hw_reset_n(hw_reset_n), .writeProt_n(writeProt_n),
    .addr_in(addr_in), .data_io_in(dataBus), .data_io_out(data_io_out), .data_io_oe(data_io_oe),
    .busy_out_n(busy_out_n), .autoStandby(autoStandby));
  flash_dev_model #(.MAKER(MAKER_ID), .DEV1(DEV_ID1), .DEV2(DEV_ID2), .DEV3(DEV_ID3))
    dev_u (.chipSel_n(chipSel_n), .outEn_n(outEn_n),
    .writeEn_n(writeEn_n), .hw_reset_n(hw_reset_n), .addr_in(addr_in), .hostOe(data_io_oe),
    .hostData(data_io_out), .busyReq(busyReq), .dataBus(dataBus), .busy_out_n(busy_out_n),
    .wrAddr(wrAddr), .wrData(wrData));
  task automatic check(string what, logic [22:0] seen, logic [22:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait for one answer pulse, bounded
  task automatic rsp;
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    while (rspValid !== 1'b1 && n < 60);
    got = rspData;
    check("answer", 23'(n >= 60), 23'h00_0000);
  endtask
  task automatic op(logic [1:0] c, logic [22:0] a, logic [15:0] d);
    @(negedge sys_clk);
    while (reqReady !== 1'b1)
      @(negedge sys_clk);
    opCode = c;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    @(negedge sys_clk);
    reqValid = 1'b0;
    check("ready", reqReady, 23'h00_0000);
    rsp();
  endtask
  task automatic t_read;
    op(`OP_READ, 23'h00_0123, 16'h0000);
    check("read", got, {7'h00, 8'h79, 8'h23});
    check("status", rspStatus, 23'h00_0023);
    repeat (6) @(negedge sys_clk);
    check("standby", autoStandby, 23'h00_0001);
    $display("read done");
  endtask
  // Page from word 5 walks up to word 7
  task automatic t_page;
    op(`OP_PAGE, 23'h00_0045, 16'h0000);
    for (int i = 5; i < 8; i++)
    begin
      if (i > 5)
        rsp();
      check("page", got, {7'h00, 8'h40 + 8'(i), 8'h40 + 8'(i)} ^ 23'h00_5A00);
    end
    $display("page done");
  endtask
  task automatic t_write;
    op(`OP_WRITE, 23'h12_3456, 16'hAB12);
    check("wr addr", wrAddr, 23'h12_3456);
    check("wr data", wrData, 23'h00_0012);
    repeat (6) @(negedge sys_clk);
    check("no standby", autoStandby, 23'h00_0000);
    $display("write done");
  endtask
  task automatic t_ident;
    op(`OP_WRITE, 23'h00_0555, 16'h0090);
    op(`OP_READ, {15'h0000, `ID_MAKER_ADDR}, 16'h0000);
    check("maker", got, {7'h00, MAKER_ID});
    op(`OP_READ, {15'h0000, `ID_DEV1_ADDR}, 16'h0000);
    check("dev1", got, {7'h00, DEV_ID1});
    op(`OP_READ, {15'h0000, `ID_DEV2_ADDR}, 16'h0000);
    check("dev2", got, {7'h00, DEV_ID2});
    op(`OP_READ, {15'h0000, `ID_DEV3_ADDR}, 16'h0000);
    check("dev3", got, {7'h00, DEV_ID3});
    op(`OP_READ, {15'h0000, `ID_XBLK_ADDR}, 16'h0000);
    check("xblk", got, 23'h00_0080);
    op(`OP_READ, {15'h0000, `ID_PROT_ADDR}, 16'h0000);
    check("prot", got, 23'h00_0001);
    op(`OP_RESET, 23'h00_0000, 16'h0000);
    op(`OP_READ, 23'h00_0000, 16'h0000);
    check("after rst", got, 23'h00_5A00);
    $display("ident done");
  endtask
  // Mode entry refused while busy; write protect follows
  task automatic t_busy;
    @(negedge sys_clk);
    busyReq = 1'b1; // Busy held across the write below, which selects the chip
    @(negedge sys_clk);
    check("busy", flashBusy, 23'h00_0001);
    op(`OP_WRITE, 23'h00_0555, 16'h0090);
    @(negedge sys_clk);
    busyReq = 1'b0;
    op(`OP_READ, 23'h00_0000, 16'h0000);
    check("refused", got, 23'h00_5A00);
    @(negedge sys_clk);
    protOuter = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("wprot", writeProt_n, 23'h00_0000);
    protOuter = 1'b0;
    $display("busy done");
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_read();
    t_page();
    t_write();
    t_ident();
    t_busy();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verilog/flash_host_ctrl.v
// Purpose: host-side controller driving the parallel flash pins
// Assumes: flash pins sampled synchronously to sys_clk
// Notes: one operation at a time; page reads walk A0-A2
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"
// Functional notes
// RULE1: Writes go to one bank only
// RULE2: Flash filters glitches under 5 ns
// RULE3: Page is 8 words, A0-A2 select
// RULE4: Read: address, chip select, output low
// RULE5: Address latched at later falling edge
// RULE6: Data latched at earlier rising edge
// RULE7: Output strobe high during every write
// RULE8: Data floats when output strobe high
// RULE9: Chip select high floats data, standby
// RULE10: Busy operation continues despite deselect
// RULE11: Reset low deselects, floats outputs
// RULE12: Idle after read gives auto standby
// RULE13: Write-protect high for outer blocks; code drives writeProt_n low when protOuter is set
// RULE14: Power-up read mode; command enters ID
// RULE15: No ID mode while busy
// RULE16: Reset ends ID mode
// RULE17: ID mode returns maker, device codes
// RULE18: Extended block indicator on DQ7
// RULE19: Bit7 factory, bit6 customer locked
// RULE20: Protection read gives 01h or 00h
// RULE21: Only low data byte is decoded
// RULE22: Device drives only during valid read
module flash_host_ctrl (
  input wire sys_clk,
  input wire reset_n,
  input wire reqValid,
  output wire reqReady,
  input wire [1:0] opCode,
  input wire [`ADDR_W-1:0] reqAddr,
  input wire [`DATA_W-1:0] reqData,
  input wire protOuter,
  output reg rspValid,
  output reg [`DATA_W-1:0] rspData,
  output reg [7:0] rspStatus,
  output wire flashBusy,
  output reg chipSel_n,
  output reg outEn_n,
  output reg writeEn_n,
  output reg hw_reset_n,
  output reg writeProt_n,
  output reg [`ADDR_W-1:0] addr_in,
  input wire [`DATA_W-1:0] data_io_in,
  output reg [`DATA_W-1:0] data_io_out,
  output reg data_io_oe,
  input wire busy_out_n,
  output reg autoStandby
);
  localparam S_IDLE = 3'd0;
  localparam S_RD = 3'd1;
  localparam S_PG = 3'd2;
  localparam S_WSET = 3'd3;
  localparam S_WLOW = 3'd4;
  localparam S_WHOLD = 3'd5;
  localparam S_RST = 3'd6;
  localparam S_GAP = 3'd7;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`PAGE_BITS-1:0] word_ff;
  reg [`CNT_W-1:0] idle_ff;
  reg lastRd_ff;
  reg tLoad;
  reg [`CNT_W-1:0] tVal;
  wire tDone;
  reg rdDone;

  // Cycle count of a nanosecond time, rounded up, at least one
  function [`CNT_W-1:0] cyc;
    input integer ns;
    integer c;
    begin
      c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      if (c < 1)
        c = 1;
      cyc = c[`CNT_W-1:0];
    end
  endfunction

  strobe_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(tLoad),
    .loadVal(tVal),
    .done(tDone)
  );

  // Flash reports busy when its ready pin is low
  assign flashBusy = ~busy_out_n;
  assign reqReady = (state_ff == S_IDLE); // One op in flight, so one bank written, see RULE1

  // Next-state and timer load
  always @*
  begin
    nxt_state = state_ff;
    tLoad = 1'b0;
    tVal = 8'h00;
    rdDone = 1'b0;
    case (state_ff)
      S_IDLE:
        if (reqValid)
        begin
          tLoad = 1'b1;
          case (opCode)
            `OP_READ:
            begin
              nxt_state = S_RD;
              tVal = cyc(`ACCESS_NS);
            end
            `OP_PAGE:
            begin
              nxt_state = S_PG;
              tVal = cyc(`ACCESS_NS);
            end
            `OP_WRITE:
            begin
              nxt_state = S_WSET;
              tVal = 8'h00;
            end
            default:
            begin
              nxt_state = S_RST;
              tVal = cyc(`RSTPULSE_NS);
            end
          endcase
        end
      S_RD:
        if (tDone)
        begin
          rdDone = 1'b1;
          nxt_state = S_GAP;
        end
      S_PG:
        if (tDone)
        begin
          rdDone = 1'b1;
          tLoad = 1'b1;
          tVal = cyc(`PAGE_NS);
          if (word_ff == `PAGE_WORDS - 1)
            nxt_state = S_GAP;
        end
      S_WSET:
        if (tDone)
        begin
          tLoad = 1'b1;
          tVal = cyc(`WRPULSE_NS);
          nxt_state = S_WLOW;
        end
      S_WLOW:
        if (tDone)
        begin
          tLoad = 1'b1;
          tVal = 8'h00;
          nxt_state = S_WHOLD;
        end
      S_WHOLD:
        if (tDone)
          nxt_state = S_IDLE;
      S_RST:
        if (tDone)
          nxt_state = S_GAP;
      S_GAP:
        nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // Pin drive, response capture and state
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= S_IDLE;
      chipSel_n <= 1'b1;
      outEn_n <= 1'b1;
      writeEn_n <= 1'b1;
      hw_reset_n <= 1'b1;
      writeProt_n <= 1'b0;
      addr_in <= 23'h00_0000;
      data_io_out <= 16'h0000;
      data_io_oe <= 1'b0;
      word_ff <= 3'h0;
      rspValid <= 1'b0;
      rspData <= 16'h0000;
      rspStatus <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      rspValid <= 1'b0;
      writeProt_n <= ~protOuter; // see RULE13
      case (state_ff)
        S_IDLE:
          if (reqValid)
          begin
            addr_in <= reqAddr;
            word_ff <= reqAddr[`PAGE_BITS-1:0];
            case (opCode)
              `OP_READ, `OP_PAGE:
              begin
                // Strobes held far above 5 ns, so glitch filter never eats them
                chipSel_n <= 1'b0; // see RULE4 see RULE2
                outEn_n <= 1'b0; // see RULE4
                writeEn_n <= 1'b1; // see RULE4
                data_io_oe <= 1'b0; // see RULE22
              end
              `OP_WRITE:
              begin
                // Address first; falling strobe latches it
                outEn_n <= 1'b1; // see RULE7
                data_io_oe <= 1'b1;
                data_io_out <= {8'h00, reqData[`CMD_BYTE_W-1:0]}; // see RULE21
              end
              default:
              begin
                hw_reset_n <= 1'b0; // see RULE11 see RULE16
                chipSel_n <= 1'b1;
                outEn_n <= 1'b1;
              end
            endcase
          end
        S_RD, S_PG:
          if (tDone)
          begin
            rspValid <= 1'b1;
            rspData <= data_io_in;
            // Low byte carries status and ID indicator bits
            rspStatus <= data_io_in[7:0]; // see RULE18 see RULE19 see RULE20 see RULE17
            if (state_ff == S_PG && word_ff != `PAGE_WORDS - 1)
            begin
              word_ff <= word_ff + 3'h1;
              addr_in <= {addr_in[`ADDR_W-1:`PAGE_BITS], word_ff + 3'h1}; // see RULE3
            end
            else
            begin
              outEn_n <= 1'b1; // see RULE8
              chipSel_n <= 1'b1; // see RULE9
            end
          end
        S_WSET:
          if (tDone)
          begin
            chipSel_n <= 1'b0;
            writeEn_n <= 1'b0; // see RULE5
          end
        S_WLOW:
          if (tDone)
          begin
            writeEn_n <= 1'b1; // see RULE6
            chipSel_n <= 1'b1;
          end
        S_WHOLD:
          if (tDone)
          begin
            data_io_oe <= 1'b0;
            rspValid <= 1'b1;
            rspData <= 16'h0000;
            rspStatus <= 8'h00;
          end
        S_RST:
          if (tDone)
          begin
            hw_reset_n <= 1'b1;
            rspValid <= 1'b1;
          end
        default:
          ;
      endcase
    end
  end

  // Idle count after a read; flash drops to standby itself
  // Host only tracks it, since the device busy state is independent
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_ff <= 8'h00;
      autoStandby <= 1'b0;
      lastRd_ff <= 1'b0;
    end
    else if (rdDone || state_ff != S_IDLE)
    begin
      idle_ff <= 8'h00;
      autoStandby <= 1'b0;
      lastRd_ff <= rdDone || (lastRd_ff && state_ff == S_GAP); // Writes and resets end the read
    end
    else if (idle_ff < `AUTOSBY_CYC)
      idle_ff <= idle_ff + 8'h01;
    else
      autoStandby <= lastRd_ff; // see RULE12
  end
endmodule
`default_nettype wire

// file: verilog/flash_host_defines.vh
// Purpose: constants for the parallel flash host controller
// Assumes: sys_clk at 20 MHz (50 ns period)
// Notes: times kept in ns, cycle counts derived from them
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
`define CLK_PERIOD_NS 50
`define ADDR_W 23
`define DATA_W 16
`define PAGE_WORDS 8
`define PAGE_BITS 3
// Glitch width under which the flash filters pulses; our strobes are held longer
`define GLITCH_NS 5
`define GLITCH_CYC (((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
// Access time assumed for strobe-to-sample wait
`define ACCESS_NS 80
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_NS 25
`define PAGE_CYC ((`PAGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write strobe low time and reset pulse width
`define WRPULSE_NS 50
`define WRPULSE_CYC ((`WRPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RSTPULSE_NS 500
`define RSTPULSE_CYC ((`RSTPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Idle time to auto standby after a read: access plus 30 ns
`define AUTOSBY_EXTRA_NS 30
`define AUTOSBY_CYC ((`ACCESS_NS + `AUTOSBY_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
// Operation codes on opCode
`define OP_READ 2'd0
`define OP_PAGE 2'd1
`define OP_WRITE 2'd2
`define OP_RESET 2'd3
// Identification read address patterns (low address bits)
`define ID_MAKER_ADDR 8'h00
`define ID_DEV1_ADDR 8'h01
`define ID_DEV2_ADDR 8'h0E
`define ID_DEV3_ADDR 8'h0F
`define ID_XBLK_ADDR 8'h03
`define ID_PROT_ADDR 8'h02
`define XBLK_FACTORY_BIT 7
`define XBLK_CUSTOMER_BIT 6
`define CMD_BYTE_W 8
`endif

// file: verilog/strobe_timer.v
// Purpose: loadable down counter giving a done pulse
// Assumes: single sys_clk domain
// Notes: load value zero gives done on the next cycle
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"
module strobe_timer (
  input wire sys_clk,
  input wire reset_n,
  input wire load,
  input wire [`CNT_W-1:0] loadVal,
  output wire done
);
  reg [`CNT_W-1:0] cnt_ff;
  reg run_ff;
  // Count down; done while running at zero
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= 8'h00;
      run_ff <= 1'b0;
    end
    else if (load)
    begin
      cnt_ff <= loadVal;
      run_ff <= 1'b1;
    end
    else if (run_ff)
    begin
      if (cnt_ff == 8'h00)
        run_ff <= 1'b0;
      else
        cnt_ff <= cnt_ff - 8'h01;
    end
  end
  assign done = run_ff && (cnt_ff == 8'h00);
endmodule
`default_nettype wire
